// *** hw/data_space_pkg.sv ***
package data_space_pkg;
  // ****************************************
  // program memory vectors
  // ****************************************
  localparam logic [23:0] VEC_RANGE_LO = 24'h00_0000;
  localparam logic [23:0] VEC_RANGE_HI = 24'h00_0020;
  localparam logic [23:0] RESET_FETCH_ADDR = 24'h00_0000;
  localparam logic [23:0] START_ADDR_WORD = 24'h00_0002;
  localparam logic [23:0] IVT_PRI_LO = 24'h00_0004;
  localparam logic [23:0] IVT_PRI_HI = 24'h00_00FF;
  localparam logic [23:0] IVT_ALT_LO = 24'h00_0100;
  localparam logic [23:0] IVT_ALT_HI = 24'h00_01FF;
  // config word bases, one per memory size
  localparam logic [23:0] CFG_BASE_0 = 24'h00_ABFA;
  localparam logic [23:0] CFG_BASE_1 = 24'h01_57FA;
  localparam logic [23:0] CFG_BASE_2 = 24'h02_0BFA;
  localparam logic [23:0] CFG_BASE_3 = 24'h02_ABFA;
  localparam int CFG_WORDS = 3;
  localparam logic [23:0] CFG_STEP = 24'h00_0002;
  // ****************************************
  // data space
  // ****************************************
  localparam int DATA_AW = 16;
  localparam int DATA_W = 16;
  localparam logic [15:0] IMPL_LIMIT = 16'h4000;
  localparam logic [15:0] NEAR_LIMIT = 16'h1FFF;
  localparam logic [15:0] SFR_LIMIT = 16'h07FF;
  localparam logic [15:0] SFR_BLOCK_BYTES = 16'h0020;
  localparam logic [15:0] TIMER_BLOCK = 16'h0100;
  localparam int SFR_BLOCK_SHIFT = 5;
  localparam int SFR_BLOCKS = 64;
  localparam logic [63:0] SFR_BLOCK_MAP = 64'h00F0_0000_0000_0303;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam int WINDOW_ENABLE_BIT = 2;
endpackage

// *** hw/addr_gen_unit.sv ***
`timescale 1ns/1ps
module addr_gen_unit (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request
  input wire logic i_valid,
  input wire logic i_byte_op,
  input wire logic i_post_inc,
  input wire logic [15:0] i_base,
  // result
  output logic [15:0] o_addr,
  output logic [15:0] o_next_ptr,
  output logic o_misaligned
);
  // ****************************************
  // pointer update and alignment
  // ****************************************
  logic [15:0] next_ptr;
  always_comb begin
    next_ptr = i_base;
    if (i_post_inc) begin
      next_ptr = i_byte_op ? i_base + data_space_pkg::BYTE_STEP
                           : i_base + data_space_pkg::WORD_STEP;
    end
  end
  assign o_addr = i_base;
  assign o_misaligned = i_valid & ~i_byte_op & i_base[0];
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_next_ptr <= 16'h0000;
    end else if (i_valid) begin
      o_next_ptr <= next_ptr;
    end
  end
endmodule // addr_gen_unit

// *** hw/byte_lane_unit.sv ***
`timescale 1ns/1ps
module byte_lane_unit (
  // operation
  input wire logic i_byte_op,
  input wire logic i_addr_lsb,
  input wire logic [15:0] i_rd_word,
  input wire logic [15:0] i_wr_data,
  // result
  output logic [15:0] o_rd_data,
  output logic [15:0] o_wr_word,
  output logic [1:0] o_lane_we
);
  // ****************************************
  // lane select
  // ****************************************
  always_comb begin
    if (i_byte_op) begin
      o_rd_data = {8'h00, i_addr_lsb ? i_rd_word[15:8]
                                     : i_rd_word[7:0]};
      o_wr_word = {i_wr_data[7:0], i_wr_data[7:0]};
      o_lane_we = i_addr_lsb ? 2'b10 : 2'b01;
    end else begin
      o_rd_data = i_rd_word;
      o_wr_word = i_wr_data;
      o_lane_we = 2'b11;
    end
  end
endmodule // byte_lane_unit

// *** hw/data_space_access_decode.sv ***
`timescale 1ns/1ps
// Summary of operation
// - vectors own program range 00000h to 00020h
// - fetch starts at zero after reset
// - two vector tables in low program memory
// - top three words copied to config on reset
// - config address depends on memory size
// - 16-bit address selects one byte
// - top address bit selects program window
// - outside 16 Kbytes reads return zero, except enabled window
// - low byte even, high byte odd
// - post increment by one or two
// - byte read selects lane onto low byte
// - shared word decode, separate lane strobes
// - odd word access raises address trap
// - misaligned read completes, write suppressed
// - byte load keeps register high byte
// - sign and zero extension of bytes
// - 13-bit direct field reaches near space
// - move uses full 16-bit direct address
// - register region unused addresses read zero
// - register region decoded in 32-byte blocks
// - separate read and write address units
// - window enable bit gates program window
module data_space_access_decode (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // memory size select 0..3
  input wire logic [1:0] i_mem_size,
  // program window enable from core control
  input wire logic i_program_window_enable,
  // config copy
  input wire logic [15:0] i_cfg_rd_data,
  output logic [23:0] o_cfg_addr,
  output logic o_cfg_rd,
  output logic [15:0] o_cfg_word0,
  output logic [15:0] o_cfg_word1,
  output logic [15:0] o_cfg_word2,
  output logic o_cfg_done,
  // fetch
  output logic [23:0] o_fetch_addr,
  output logic o_vector_region,
  output logic o_ivt_region,
  // read request
  input wire logic i_rd_valid,
  input wire logic i_rd_byte,
  input wire logic i_rd_post_inc,
  input wire logic i_rd_direct,
  input wire logic i_rd_mov,
  input wire logic [15:0] i_rd_base,
  input wire logic [12:0] i_rd_near_field,
  // write request
  input wire logic i_wr_valid,
  input wire logic i_wr_byte,
  input wire logic i_wr_post_inc,
  input wire logic i_wr_direct,
  input wire logic i_wr_mov,
  input wire logic [15:0] i_wr_base,
  input wire logic [12:0] i_wr_near_field,
  input wire logic [15:0] i_wr_data,
  // memory side
  input wire logic [15:0] i_mem_rd_word,
  input wire logic [15:0] i_sfr_rd_word,
  input wire logic [15:0] i_window_rd_word,
  output logic [14:0] o_mem_word_addr,
  output logic [15:0] o_mem_wr_word,
  output logic [1:0] o_mem_lane_we,
  output logic [1:0] o_sfr_lane_we,
  output logic [5:0] o_sfr_block,
  output logic o_window_rd,
  // results
  output logic [15:0] o_rd_data,
  output logic [15:0] o_rd_next_ptr,
  output logic [15:0] o_wr_next_ptr,
  output logic o_addr_trap,
  // working register byte ops
  input wire logic [15:0] i_source_working_register,
  input wire logic [1:0] i_wreg_op,
  output logic [15:0] o_wreg_result
);
  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [15:0] eff_addr(input logic direct,
      input logic mov, input logic [12:0] near, input logic [15:0] base);
    if (direct && !mov) begin
      eff_addr = {3'b000, near};
    end else begin
      eff_addr = base;
    end
  endfunction
  function automatic logic sfr_hit(input logic [15:0] a);
    logic [5:0] blk;
    blk = a[10:5];
    sfr_hit = (a <= data_space_pkg::SFR_LIMIT)
      && data_space_pkg::SFR_BLOCK_MAP[blk];
  endfunction
  function automatic logic mem_hit(input logic [15:0] a);
    mem_hit = (a < data_space_pkg::IMPL_LIMIT)
      && (a > data_space_pkg::SFR_LIMIT);
  endfunction

  // ****************************************
  // address generation units
  // ****************************************
  logic [15:0] rd_ea;
  logic [15:0] wr_ea;
  logic rd_mis;
  logic wr_mis;
  addr_gen_unit rd_unit (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(i_rd_valid),
    .i_byte_op(i_rd_byte),
    .i_post_inc(i_rd_post_inc),
    .i_base(eff_addr(i_rd_direct, i_rd_mov, i_rd_near_field, i_rd_base)),
    .o_addr(rd_ea),
    .o_next_ptr(o_rd_next_ptr),
    .o_misaligned(rd_mis)
  );
  addr_gen_unit wr_unit (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(i_wr_valid),
    .i_byte_op(i_wr_byte),
    .i_post_inc(i_wr_post_inc),
    .i_base(eff_addr(i_wr_direct, i_wr_mov, i_wr_near_field, i_wr_base)),
    .o_addr(wr_ea),
    .o_next_ptr(o_wr_next_ptr),
    .o_misaligned(wr_mis)
  );

  // ****************************************
  // read path
  // ****************************************
  logic rd_window;
  logic [15:0] rd_word;
  logic [15:0] rd_lane;
  assign rd_window = rd_ea[15] & i_program_window_enable;
  always_comb begin
    if (rd_window) begin
      rd_word = i_window_rd_word;
    end else if (!rd_ea[15] && sfr_hit(rd_ea)) begin
      rd_word = i_sfr_rd_word;
    end else if (!rd_ea[15] && mem_hit(rd_ea)) begin
      rd_word = i_mem_rd_word;
    end else begin
      rd_word = 16'h0000;
    end
  end
  byte_lane_unit rd_lanes (
    .i_byte_op(i_rd_byte),
    .i_addr_lsb(rd_ea[0]),
    .i_rd_word(rd_word),
    .i_wr_data(16'h0000),
    .o_rd_data(rd_lane),
    .o_wr_word(),
    .o_lane_we()
  );
  // misaligned read still completes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rd_data <= 16'h0000;
    end else if (i_rd_valid) begin
      o_rd_data <= rd_lane;
    end
  end
  assign o_window_rd = i_rd_valid & rd_window;

  // ****************************************
  // write path
  // ****************************************
  logic [1:0] wr_lanes;
  logic wr_ok;
  byte_lane_unit wr_lane_sel (
    .i_byte_op(i_wr_byte),
    .i_addr_lsb(wr_ea[0]),
    .i_rd_word(16'h0000),
    .i_wr_data(i_wr_data),
    .o_rd_data(),
    .o_wr_word(o_mem_wr_word),
    .o_lane_we(wr_lanes)
  );
  assign wr_ok = i_wr_valid & ~wr_mis & ~wr_ea[15];
  assign o_mem_lane_we = (wr_ok && mem_hit(wr_ea))
    ? wr_lanes : 2'b00;
  assign o_sfr_lane_we = (wr_ok && sfr_hit(wr_ea))
    ? wr_lanes : 2'b00;
  assign o_mem_word_addr = i_wr_valid ? wr_ea[15:1] : rd_ea[15:1];
  assign o_sfr_block = i_wr_valid ? wr_ea[10:5] : rd_ea[10:5];

  // ****************************************
  // address error trap, after the instruction
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_addr_trap <= 1'b0;
    end else begin
      o_addr_trap <= rd_mis | wr_mis;
    end
  end

  // ****************************************
  // working register byte operations
  // ****************************************
  always_comb begin
    case (i_wreg_op)
      2'd1: o_wreg_result = {i_source_working_register[15:8],
        rd_lane[7:0]};
      2'd2: o_wreg_result = {{8{i_source_working_register[7]}},
        i_source_working_register[7:0]};
      2'd3: o_wreg_result = {8'h00,
        i_source_working_register[7:0]};
      default: o_wreg_result = i_source_working_register;
    endcase
  end

  // ****************************************
  // reset configuration copy
  // ****************************************
  typedef enum logic [1:0] {CFG_READ, CFG_IDLE} cfg_state_e;
  cfg_state_e cfg_state;
  logic [1:0] cfg_idx;
  logic [23:0] cfg_base;
  always_comb begin
    case (i_mem_size)
      2'd0: cfg_base = data_space_pkg::CFG_BASE_0;
      2'd1: cfg_base = data_space_pkg::CFG_BASE_1;
      2'd2: cfg_base = data_space_pkg::CFG_BASE_2;
      default: cfg_base = data_space_pkg::CFG_BASE_3;
    endcase
  end
  assign o_cfg_addr = cfg_base
    + (data_space_pkg::CFG_STEP * {22'd0, cfg_idx});
  assign o_cfg_rd = (cfg_state == CFG_READ);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_state <= CFG_READ;
      cfg_idx <= 2'd0;
      o_cfg_word0 <= 16'h0000;
      o_cfg_word1 <= 16'h0000;
      o_cfg_word2 <= 16'h0000;
    end else begin
      case (cfg_state)
        CFG_READ: begin
          case (cfg_idx)
            2'd0: o_cfg_word0 <= i_cfg_rd_data;
            2'd1: o_cfg_word1 <= i_cfg_rd_data;
            default: o_cfg_word2 <= i_cfg_rd_data;
          endcase
          if (cfg_idx == 2'(data_space_pkg::CFG_WORDS - 1)) begin
            cfg_state <= CFG_IDLE;
          end
          cfg_idx <= cfg_idx + 2'd1;
        end
        default: cfg_state <= CFG_IDLE;
      endcase
    end
  end
  assign o_cfg_done = (cfg_state == CFG_IDLE);

  // ****************************************
  // fetch start and vector regions
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_fetch_addr <= data_space_pkg::RESET_FETCH_ADDR;
    end else if (cfg_state == CFG_READ) begin
      o_fetch_addr <= data_space_pkg::RESET_FETCH_ADDR;
    end else begin
      o_fetch_addr <= data_space_pkg::START_ADDR_WORD;
    end
  end
  assign o_vector_region = (o_fetch_addr <= data_space_pkg::VEC_RANGE_HI)
    && (o_fetch_addr >= data_space_pkg::VEC_RANGE_LO);
  assign o_ivt_region = ((o_fetch_addr >= data_space_pkg::IVT_PRI_LO)
    && (o_fetch_addr <= data_space_pkg::IVT_PRI_HI))
    || ((o_fetch_addr >= data_space_pkg::IVT_ALT_LO)
    && (o_fetch_addr <= data_space_pkg::IVT_ALT_HI));

  // ****************************************
  // checks
  // ****************************************
  sequence s_word_odd_wr;
    i_wr_valid && !i_wr_byte && wr_ea[0];
  endsequence
  a_odd_word_trap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_rd_valid && !i_rd_byte && rd_ea[0]) |=> o_addr_trap)
    else $error("odd word read without trap");
  a_write_suppress: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_word_odd_wr |-> (o_mem_lane_we == 2'b00)
    && (o_sfr_lane_we == 2'b00) ##1 o_addr_trap)
    else $error("misaligned write not suppressed");
  a_byte_no_trap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_rd_byte || !i_rd_valid) && (i_wr_byte || !i_wr_valid)
    |=> !o_addr_trap)
    else $error("byte access trapped");
  a_unimpl_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rd_valid && !rd_ea[15] && !sfr_hit(rd_ea) && !mem_hit(rd_ea)
    |=> o_rd_data == 16'h0000)
    else $error("unimplemented read not zero");
  a_byte_lane_we: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wr_valid && i_wr_byte && mem_hit(wr_ea)
    |-> o_mem_lane_we == (wr_ea[0] ? 2'b10 : 2'b01))
    else $error("wrong lane strobe");
  a_ptr_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_rd_valid && i_rd_post_inc
    |=> o_rd_next_ptr == $past(rd_ea) + ($past(i_rd_byte) ? 16'h0001
    : 16'h0002))
    else $error("pointer step wrong");
  a_window_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_program_window_enable |-> !o_window_rd)
    else $error("window visible while disabled");
  a_cfg_copy: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> o_cfg_rd ##3 o_cfg_done)
    else $error("config copy not three words");
  a_byte_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wreg_op == 2'd1 |-> o_wreg_result[15:8]
    == i_source_working_register[15:8])
    else $error("byte load touched high byte");
endmodule // data_space_access_decode

// *** verif/core_mem_model.sv ***
`timescale 1ns/1ps
module core_mem_model (
  // clock
  input wire logic i_clk,
  // data memory
  input wire logic [14:0] i_word_addr,
  input wire logic [15:0] i_wr_word,
  input wire logic [1:0] i_lane_we,
  output logic [15:0] o_rd_word,
  // config memory
  input wire logic [23:0] i_cfg_addr,
  output logic [15:0] o_cfg_data
);
  // ****
  // word array, one strobe a lane
  // ****
  logic [15:0] mem [0:8191];
  always @(posedge i_clk) begin
    if (i_lane_we[0]) mem[i_word_addr[12:0]][7:0] <= i_wr_word[7:0];
    if (i_lane_we[1]) begin
      mem[i_word_addr[12:0]][15:8] <= i_wr_word[15:8];
    end
  end
  assign o_rd_word = mem[i_word_addr[12:0]];
  assign o_cfg_data = i_cfg_addr[15:0] ^ 16'h5A5A;
endmodule // core_mem_model

// *** verif/data_space_access_decode_tb.sv ***
`timescale 1ns/1ps
module data_space_access_decode_tb;
  logic i_clk = 0, i_rst_n = 0, pwe = 0, rv = 0, rb = 0, rd = 0, rm = 0;
  logic wv = 0, wb = 0, trap, vec, ivt, cfg_rd, done, win_rd, pinc = 1;
  logic [1:0] size = 0, op = 0, mwe, swe;
  logic [15:0] rbase = 0, wbase = 0, wdat = 0, src = 0, mrd, cdat;
  logic [15:0] sfr_w = 16'hC3C3, win_w = 16'h7E81, w0, w1, w2, mwr;
  logic [15:0] rdat, rnext, wnext, wres;
  logic [12:0] rnear = 0;
  logic [23:0] caddr, faddr;
  logic [14:0] maddr;
  logic [5:0] blk;
  int bad_count = 0, num_checks = 0;
  always #5 i_clk = ~i_clk;
  data_space_access_decode i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_mem_size(size), .i_program_window_enable(pwe), .i_cfg_rd_data(cdat),
    .o_cfg_addr(caddr), .o_cfg_rd(cfg_rd), .o_cfg_word0(w0),
    .o_cfg_word1(w1), .o_cfg_word2(w2), .o_cfg_done(done),
    .o_fetch_addr(faddr), .o_vector_region(vec), .o_ivt_region(ivt),
    .i_rd_valid(rv), .i_rd_byte(rb), .i_rd_post_inc(pinc),
    .i_rd_direct(rd), .i_rd_mov(rm), .i_rd_base(rbase),
    .i_rd_near_field(rnear), .i_wr_valid(wv), .i_wr_byte(wb),
    .i_wr_post_inc(1'b1), .i_wr_direct(1'b0), .i_wr_mov(1'b0),
    .i_wr_base(wbase), .i_wr_near_field(13'h0000), .i_wr_data(wdat),
    .i_mem_rd_word(mrd), .i_sfr_rd_word(sfr_w), .i_window_rd_word(win_w),
    .o_mem_word_addr(maddr), .o_mem_wr_word(mwr), .o_mem_lane_we(mwe),
    .o_sfr_lane_we(swe), .o_sfr_block(blk), .o_window_rd(win_rd),
    .o_rd_data(rdat), .o_rd_next_ptr(rnext), .o_wr_next_ptr(wnext),
    .o_addr_trap(trap), .i_source_working_register(src),
    .i_wreg_op(op), .o_wreg_result(wres));
  core_mem_model i_mem (.i_clk(i_clk), .i_word_addr(maddr),
    .i_wr_word(mwr), .i_lane_we(mwe), .o_rd_word(mrd),
    .i_cfg_addr(caddr), .o_cfg_data(cdat));
  // ****
  // shared tasks
  // ****
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rd_op(input logic b, dir, mov, input logic [15:0] a,
      input logic [15:0] exp, input logic tr, ck);
    @(posedge i_clk);
    rv <= 1; rb <= b; rd <= dir; rm <= mov; rnear <= a[12:0];
    rbase <= (dir && !mov) ? 16'h3000 : a;
    #1;
    check(win_rd, pwe && a[15]);
    @(posedge i_clk);
    rv <= 0;
    #1;
    if (ck) check(rdat, exp);
    check(trap, tr);
    if (!dir) check(rnext, a + (!pinc ? 16'h0000 : b ? 16'h0001
      : 16'h0002));
  endtask
  task automatic wr_op(input logic b, input logic [15:0] a, d,
      input logic [1:0] we, input logic tr);
    @(posedge i_clk);
    wv <= 1; wb <= b; wbase <= a; wdat <= d;
    #1;
    check(mwe, a >= 16'h0800 ? we : 2'b00);
    check(swe, a < 16'h0800 ? we : 2'b00);
    @(posedge i_clk);
    wv <= 0;
    #1;
    check(trap, tr);
    check(wnext, a + (b ? 16'h0001 : 16'h0002));
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    logic [23:0] base;
    for (int s = 0; s < 4; s++) begin
      @(posedge i_clk);
      i_rst_n <= 0; size <= s[1:0];
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1;
      @(posedge i_clk);
      #1;
      check(faddr, 24'h00_0000);
      check(cfg_rd, 1'b1);
      for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge i_clk);
      if (done !== 1'b1) begin
        check(done, 1'b1);
        end_of_test();
      end
      @(posedge i_clk);
      #1;
      base = s == 0 ? data_space_pkg::CFG_BASE_0 :
             s == 1 ? data_space_pkg::CFG_BASE_1 :
             s == 2 ? data_space_pkg::CFG_BASE_2 : data_space_pkg::CFG_BASE_3;
      check(w0, base[15:0] ^ 16'h5A5A);
      check(w1, (base[15:0] + 16'h0002) ^ 16'h5A5A);
      check(w2, (base[15:0] + 16'h0004) ^ 16'h5A5A);
      check(faddr, 24'h00_0002);
      check({vec, ivt, cfg_rd}, 3'b100);
    end
    $display("test reset done");
  endtask
  task automatic t_lanes();
    wr_op(0, 16'h0800, 16'h1234, 2'b11, 0);
    rd_op(1, 0, 0, 16'h0800, 16'h0034, 0, 1);
    rd_op(1, 0, 0, 16'h0801, 16'h0012, 0, 1);
    wr_op(1, 16'h0801, 16'h00AB, 2'b10, 0);
    rd_op(0, 0, 0, 16'h0800, 16'hAB34, 0, 1);
    wr_op(0, 16'h0801, 16'h5555, 2'b00, 1);
    rd_op(0, 0, 0, 16'h0803, 16'h0000, 1, 0);
    rd_op(0, 0, 0, 16'h0800, 16'hAB34, 0, 1);
    $display("test lanes done");
  endtask
  task automatic t_space();
    wr_op(0, 16'h5000, 16'hFFFF, 2'b00, 0);
    wr_op(0, 16'h2800, 16'hCD00, 2'b11, 0);
    wr_op(1, 16'h0681, 16'h0077, 2'b10, 0);
    wr_op(0, 16'h0500, 16'h1111, 2'b00, 0);
    rd_op(0, 0, 0, 16'h5000, 16'h0000, 0, 1);
    pinc <= 0;
    rd_op(0, 0, 0, 16'h5000, 16'h0000, 0, 1);
    pinc <= 1;
    rd_op(1, 1, 0, 16'h0800, 16'h0034, 0, 1);
    rd_op(1, 1, 1, 16'h2801, 16'h00CD, 0, 1);
    pwe <= 1;
    rd_op(0, 0, 0, 16'h8000, 16'h7E81, 0, 1);
    pwe <= 0;
    rd_op(0, 0, 0, 16'h8000, 16'h0000, 0, 1);
    rd_op(0, 0, 0, 16'h0680, 16'hC3C3, 0, 1);
    rd_op(0, 0, 0, 16'h0500, 16'h0000, 0, 1);
    rd_op(0, 0, 0, 16'h0100, 16'hC3C3, 0, 1);
    check(blk, 6'h08);
    $display("test space done");
  endtask
  task automatic t_wreg();
    logic [15:0] exp [4] = '{16'h1280, 16'hFF80, 16'h0080, 16'h12C3};
    src <= 16'h1280;
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      op <= i == 0 ? 2'd0 : i == 3 ? 2'd1 : i[1:0] + 2'd1;
      #1;
      check(wres, exp[i]);
    end
    $display("test wreg done");
  endtask
  initial begin
    t_reset();
    t_lanes();
    t_space();
    t_wreg();
    end_of_test();
  end
endmodule // data_space_access_decode_tb
